// ### src/status_pkg.sv
// shared constants for the status reporting block
package status_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int NARROW_W = 8;
	localparam int WIDE_W   = 16;
	localparam int WIDE_MSB = 15;

	// ------------------------------------------------------------
	// status byte bit positions
	// ------------------------------------------------------------
	localparam int STB_QUES = 3;
	localparam int STB_MAV  = 4;
	localparam int STB_ESB  = 5;
	localparam int STB_RQS  = 6;
	localparam int STB_OPER = 7;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_NARROW = 8'h00;
	localparam logic [15:0] RST_WIDE   = 16'h0000;

	// service request state, gray coded
	typedef enum logic [1:0] {
		SRQ_IDLE    = 2'b00,
		SRQ_PENDING = 2'b01
	} srq_state_t;
endpackage

// ### src/status_set.sv
// one register set: condition, event latch and enable with summary
`timescale 1ns/100ps
module status_set #(
	parameter int W = 16,
	parameter bit TOP_ZERO = 1'b1
) (
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	input  wire logic [W-1:0] i_cond,
	input  wire logic         i_evt_rd,
	input  wire logic         i_clear,
	input  wire logic         i_en_wr,
	input  wire logic [W-1:0] i_en_data,
	output logic      [W-1:0] o_cond,
	output logic      [W-1:0] o_event,
	output logic      [W-1:0] o_enable,
	output logic              o_summary
);
	typedef struct packed {
		logic [W-1:0] prev;
		logic [W-1:0] cond;
		logic [W-1:0] evt;
		logic [W-1:0] en;
		logic         sum;
	} set_t;

	set_t st;
	set_t next_st;
	logic [W-1:0] mask;

	// top bit of wide sets never reports
	assign mask = TOP_ZERO ? {1'b0, {(W-1){1'b1}}} : {W{1'b1}};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [W-1:0] change;
		logic [W-1:0] evt_n;
		change = (i_cond ^ st.prev) & mask;
		evt_n = st.evt;
		next_st = st;
		next_st.prev = i_cond & mask;
		next_st.cond = i_cond & mask;
		if (i_evt_rd || i_clear) begin
			evt_n = '0;
		end
		// a change in the clearing cycle still lands
		evt_n = evt_n | change;
		next_st.evt = evt_n;
		if (i_en_wr) begin
			next_st.en = i_en_data & mask;
		end
		next_st.sum = |(evt_n & next_st.en);
	end

	// event and enable state clears on reset
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_cond    = st.cond;
	assign o_event   = st.evt;
	assign o_enable  = st.en;
	assign o_summary = st.sum;
endmodule

// ### src/srq_engine.sv
// service request generation from status byte summaries
`timescale 1ns/100ps
module srq_engine (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic [7:0] i_summary,
	input  wire logic [7:0] i_srq_en,
	input  wire logic       i_poll,
	output logic            o_rqs
);
	typedef struct packed {
		logic [7:0]             prev;
		status_pkg::srq_state_t state;
	} srq_t;

	srq_t st;
	srq_t next_st;

	// ------------------------------------------------------------
	// start on enabled rising summary when not already pending
	// ------------------------------------------------------------
	always_comb begin
		logic rise;
		rise = |(i_summary & ~st.prev & i_srq_en);
		next_st = st;
		next_st.prev = i_summary;
		case (st.state)
			status_pkg::SRQ_IDLE: begin
				if (rise) begin
					next_st.state = status_pkg::SRQ_PENDING;
				end
			end
			status_pkg::SRQ_PENDING: begin
				// serial poll ends pending; new rises ignored meanwhile
				if (i_poll) begin
					next_st.state = status_pkg::SRQ_IDLE;
				end
			end
			default: next_st.state = status_pkg::SRQ_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rqs = (st.state == status_pkg::SRQ_PENDING);
endmodule

// ### src/status_reporting_srq.sv
// top of the status reporting and service request block
`timescale 1ns/100ps

// How it works
// - status byte and standard event 8 bits; others 16, bit 15 zero
// - condition bits follow their inputs one cycle later, no latching
// - condition registers cannot be written
// - a condition change sets its event bit, sticky until cleared
// - reading an event register returns it then clears it
// - clear-status clears all event registers together
// - event registers cannot be written; only condition changes, set pulses and clearing change them
// - summary is OR of event AND enable bits
// - enable registers read back the last written value
// - request starts on enabled summary rise with none pending
// - request pending until serial poll reads the status byte
// - starting a request drives SRQ and sets request-service bit
// - serial poll clears request-service bit only
// - bit 6 is request-service on poll, master summary on query
// - status byte bits 3,4,5,7: questionable, message, event, operational
// - service-request enable bit 6 always reads zero
// - clear-status leaves enable registers alone
module status_reporting_srq (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic [15:0] i_ques_cond,
	input  wire logic [15:0] i_oper_cond,
	input  wire logic [7:0]  i_std_event_set,
	input  wire logic        i_msg_avail,
	input  wire logic        i_clear_status,
	input  wire logic        i_ques_evt_rd,
	input  wire logic        i_oper_evt_rd,
	input  wire logic        i_std_evt_rd,
	input  wire logic        i_ques_en_wr,
	input  wire logic [15:0] i_ques_en_data,
	input  wire logic        i_oper_en_wr,
	input  wire logic [15:0] i_oper_en_data,
	input  wire logic        i_std_en_wr,
	input  wire logic [7:0]  i_std_en_data,
	input  wire logic        i_srq_en_wr,
	input  wire logic [7:0]  i_srq_en_data,
	input  wire logic        i_serial_poll,
	output logic      [15:0] o_ques_cond,
	output logic      [15:0] o_ques_event,
	output logic      [15:0] o_ques_enable,
	output logic      [15:0] o_oper_cond,
	output logic      [15:0] o_oper_event,
	output logic      [15:0] o_oper_enable,
	output logic      [7:0]  o_std_event,
	output logic      [7:0]  o_std_enable,
	output logic      [7:0]  o_srq_enable,
	output logic      [7:0]  o_stb_query,
	output logic      [7:0]  o_stb_poll,
	output logic             o_srq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] std_evt;
		logic [7:0] std_en;
		logic [7:0] srq_en;
		logic [7:0] stb_q;
		logic [7:0] stb_p;
		logic       srq;
	} top_t;

	top_t st;
	top_t next_st;

	logic        ques_sum;
	logic        oper_sum;
	logic        std_sum;
	logic [7:0]  summary;
	logic        rqs;

	// ------------------------------------------------------------
	// wide register sets
	// ------------------------------------------------------------
	status_set #(
		.W        (status_pkg::WIDE_W),
		.TOP_ZERO (1'b1)
	) u_ques (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_cond    (i_ques_cond),
		.i_evt_rd  (i_ques_evt_rd),
		.i_clear   (i_clear_status),
		.i_en_wr   (i_ques_en_wr),
		.i_en_data (i_ques_en_data),
		.o_cond    (o_ques_cond),
		.o_event   (o_ques_event),
		.o_enable  (o_ques_enable),
		.o_summary (ques_sum)
	);

	status_set #(
		.W        (status_pkg::WIDE_W),
		.TOP_ZERO (1'b1)
	) u_oper (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_cond    (i_oper_cond),
		.i_evt_rd  (i_oper_evt_rd),
		.i_clear   (i_clear_status),
		.i_en_wr   (i_oper_en_wr),
		.i_en_data (i_oper_en_data),
		.o_cond    (o_oper_cond),
		.o_event   (o_oper_event),
		.o_enable  (o_oper_enable),
		.o_summary (oper_sum)
	);

	// ------------------------------------------------------------
	// status byte summaries and service request
	// ------------------------------------------------------------
	// the standard set has no condition stage, so its summary is
	// taken from registered state and changes in the same cycle as the event register
	assign std_sum = |(st.std_evt & st.std_en);

	always_comb begin
		summary = 8'h00;
		summary[status_pkg::STB_QUES] = ques_sum;
		summary[status_pkg::STB_MAV]  = i_msg_avail;
		summary[status_pkg::STB_ESB]  = std_sum;
		summary[status_pkg::STB_OPER] = oper_sum;
	end

	srq_engine u_srq (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_summary (summary),
		.i_srq_en  (st.srq_en),
		.i_poll    (i_serial_poll),
		.o_rqs     (rqs)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] sb;
		sb = summary;
		next_st = st;
		// standard event: set pulses win over any clear
		if (i_std_evt_rd || i_clear_status) begin
			next_st.std_evt = 8'h00;
		end
		next_st.std_evt = next_st.std_evt | i_std_event_set;
		if (i_std_en_wr) begin
			next_st.std_en = i_std_en_data;
		end
		if (i_srq_en_wr) begin
			next_st.srq_en = i_srq_en_data;
		end
		next_st.srq_en[status_pkg::STB_RQS] = 1'b0;
		// master summary for the query view
		sb[status_pkg::STB_RQS] = |(summary & next_st.srq_en);
		next_st.stb_q = sb;
		// poll view carries request-service instead
		sb[status_pkg::STB_RQS] = rqs;
		next_st.stb_p = sb;
		next_st.srq = rqs;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_std_event  = st.std_evt;
	assign o_std_enable = st.std_en;
	assign o_srq_enable = st.srq_en;
	assign o_stb_query  = st.stb_q;
	assign o_stb_poll   = st.stb_p;
	assign o_srq        = st.srq;
endmodule

// ### tb/ctl_model.sv
// bus controller model that answers service requests with a serial poll
`timescale 1ns/100ps
module ctl_model (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_srq,
	input  wire logic       i_slow,
	input  wire logic [7:0] i_stb_poll,
	output logic            o_poll,
	output logic      [7:0] o_seen
);
	logic [3:0] wait_cnt;

	// one poll per raised line; the count saturates so a line that
	// stays high is never polled twice
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wait_cnt <= 4'h0;
			o_poll <= 1'b0;
			o_seen <= 8'h00;
		end else begin
			o_poll <= i_srq && (wait_cnt == (i_slow ? 4'h8 : 4'h1));
			if (o_poll) begin
				o_seen <= i_stb_poll;
			end
			if (!i_srq) begin
				wait_cnt <= 4'h0;
			end else if (wait_cnt != 4'hf) begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule

// ### tb/status_chk.sv
// assertion checker for the status reporting block
`timescale 1ns/100ps
module status_chk (
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic [15:0] i_ques_cond,
	input wire logic        i_ques_evt_rd,
	input wire logic        i_clear_status,
	input wire logic        i_ques_en_wr,
	input wire logic [15:0] i_ques_en_data,
	input wire logic        i_srq_en_wr,
	input wire logic [7:0]  i_srq_en_data,
	input wire logic        i_serial_poll,
	input wire logic [15:0] o_ques_cond,
	input wire logic [15:0] o_ques_event,
	input wire logic [15:0] o_ques_enable,
	input wire logic [7:0]  o_srq_enable,
	input wire logic [7:0]  o_stb_query,
	input wire logic [7:0]  o_stb_poll,
	input wire logic        o_srq
);
	logic [1:0] age;

	// history is only trusted two edges after reset
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			age <= 2'h0;
		end else begin
			age <= {age[0], 1'b1};
		end
	end

	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	property p_width;
		!(o_ques_cond[15] | o_ques_event[15] | o_srq_enable[6]);
	endproperty
	a_width: assert property (p_width) else $error("top bit set");
	property p_live;
		age[1] |-> o_ques_cond == ($past(i_ques_cond) & 16'h7fff);
	endproperty
	a_live: assert property (p_live) else $error("cond lag");
	property p_latch;
		age[1] && !$past(i_ques_evt_rd | i_clear_status) |-> o_ques_event ==
			($past(o_ques_event) | (o_ques_cond ^ $past(o_ques_cond)));
	endproperty
	a_latch: assert property (p_latch) else $error("event latch");
	property p_rdclr;
		age[1] && $past(i_ques_evt_rd | i_clear_status) |->
			o_ques_event == (o_ques_cond ^ $past(o_ques_cond));
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("event clear");
	property p_enable;
		age[1] |-> o_ques_enable == ($past(i_ques_en_wr) ?
			$past(i_ques_en_data) & 16'h7fff : $past(o_ques_enable));
	endproperty
	a_enable: assert property (p_enable) else $error("enable");
	property p_srqen;
		age[1] && $past(i_srq_en_wr) |->
			o_srq_enable == ($past(i_srq_en_data) & 8'hbf);
	endproperty
	a_srqen: assert property (p_srqen) else $error("srq enable");
	property p_sum;
		age[1] |-> o_stb_query[3] == $past(|(o_ques_event & o_ques_enable));
	endproperty
	a_sum: assert property (p_sum) else $error("summary");
	property p_views;
		((o_stb_poll ^ o_stb_query) & 8'hbf) == 8'h00 && o_srq == o_stb_poll[6];
	endproperty
	a_views: assert property (p_views) else $error("views");
	property p_start;
		$rose(o_srq) |-> ($past(o_stb_query & o_srq_enable) & 8'hbf) != 8'h00;
	endproperty
	a_start: assert property (p_start) else $error("start");
	property p_hold;
		o_srq && !i_serial_poll && !$past(i_serial_poll) |=> o_srq;
	endproperty
	a_hold: assert property (p_hold) else $error("srq dropped");
	property p_drop;
		i_serial_poll |-> ##[2:3] !o_srq;
	endproperty
	a_drop: assert property (p_drop) else $error("srq stuck");

	cover property ($rose(o_srq));
	cover property (o_srq && i_serial_poll);
	cover property (i_clear_status && o_ques_event != 16'h0000);
endmodule

bind status_reporting_srq status_chk chk (.i_clk, .i_arst_n, .i_ques_cond,
	.i_ques_evt_rd, .i_clear_status, .i_ques_en_wr, .i_ques_en_data,
	.i_srq_en_wr, .i_srq_en_data, .i_serial_poll, .o_ques_cond,
	.o_ques_event, .o_ques_enable, .o_srq_enable, .o_stb_query,
	.o_stb_poll, .o_srq);

// ### tb/testbench.sv
// self-checking bench for the status reporting block
`timescale 1ns/100ps
module testbench;
	logic        i_clk, i_arst_n, i_msg_avail, i_clear_status, slow;
	logic        i_ques_evt_rd, i_oper_evt_rd, i_std_evt_rd, i_serial_poll;
	logic        i_ques_en_wr, i_oper_en_wr, i_std_en_wr, i_srq_en_wr;
	logic [15:0] i_ques_cond, i_oper_cond, i_ques_en_data, i_oper_en_data;
	logic [7:0]  i_std_event_set, i_std_en_data, i_srq_en_data, seen;
	logic [15:0] o_ques_cond, o_ques_event, o_ques_enable, o_oper_cond;
	logic [15:0] o_oper_event, o_oper_enable;
	logic [7:0]  o_std_event, o_std_enable, o_srq_enable, o_stb_query;
	logic [7:0]  o_stb_poll;
	logic        o_srq;
	logic [31:0] r;
	int          mismatches, cmp_count, seed, i;

	status_reporting_srq dut (.*);
	ctl_model ctl (.i_clk, .i_arst_n, .i_srq(o_srq), .i_slow(slow),
		.i_stb_poll(o_stb_poll), .o_poll(i_serial_poll), .o_seen(seen));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	function automatic logic [15:0] wide(input logic [15:0] v);
		return v & 16'h7fff;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic tally_and_finish();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// bounded wait on the request line; running out is a mismatch
	task automatic wait_srq(input logic lvl);
		for (i = 0; i < 40 && o_srq !== lvl; i++) @(negedge i_clk);
		chk({15'h0000, o_srq}, {15'h0000, lvl});
		if (o_srq !== lvl) tally_and_finish();
	endtask

	// pulse one event read of the operational set
	task automatic oper_read();
		cyc(1);
		i_oper_evt_rd <= 1'b1;
		cyc(1);
		i_oper_evt_rd <= 1'b0;
	endtask

	initial begin
		seed = 77;
		{mismatches, cmp_count} = 64'h0;
		{i_arst_n, i_msg_avail, i_clear_status, slow} = 4'h0;
		{i_ques_evt_rd, i_oper_evt_rd, i_std_evt_rd} = 3'h0;
		{i_ques_en_wr, i_oper_en_wr, i_std_en_wr, i_srq_en_wr} = 4'h0;
		{i_ques_cond, i_oper_cond, i_ques_en_data, i_oper_en_data} = 64'h0;
		{i_std_event_set, i_std_en_data, i_srq_en_data} = 24'h0;
		cyc(16);
		chk(o_ques_enable | o_oper_event, 16'h0000);
		chk({o_std_event, 7'h00, o_srq}, 16'h0000);
		i_arst_n <= 1'b1;
		// enables read back, all-ones first as the boundary
		for (int k = 0; k < 6; k++) begin
			cyc(1);
			r = (k == 0) ? 32'hffff : $random(seed);
			{i_ques_en_wr, i_srq_en_wr} <= 2'h3;
			{i_ques_en_data, i_srq_en_data} <= {r[15:0], r[7:0]};
			cyc(1);
			{i_ques_en_wr, i_srq_en_wr} <= 2'h0;
			@(negedge i_clk);
			chk(o_ques_enable, wide(r[15:0]));
			chk({8'h00, o_srq_enable}, {8'h00, r[7:0] & 8'hbf});
		end
		cyc(1);
		{i_oper_en_wr, i_std_en_wr, i_srq_en_wr} <= 3'h7;
		{i_oper_en_data, i_std_en_data, i_srq_en_data} <= 32'h0010_ff80;
		r = $random(seed) | 32'h8001;
		i_ques_cond <= r[15:0];
		cyc(1);
		{i_oper_en_wr, i_std_en_wr, i_srq_en_wr} <= 3'h0;
		cyc(1);
		i_ques_cond <= 16'h0000;
		@(negedge i_clk);
		chk(o_ques_cond, wide(r[15:0]));
		cyc(2);
		@(negedge i_clk);
		chk(o_ques_cond, 16'h0000);
		chk(o_ques_event, wide(r[15:0]));
		cyc(1);
		i_ques_evt_rd <= 1'b1;
		i_std_event_set <= 8'h5a;
		cyc(1);
		{i_ques_evt_rd, i_std_event_set} <= 9'h000;
		@(negedge i_clk);
		chk(o_ques_event, 16'h0000);
		chk({8'h00, o_std_event}, 16'h005a);
		cyc(1);
		i_clear_status <= 1'b1;
		cyc(1);
		i_clear_status <= 1'b0;
		@(negedge i_clk);
		chk({o_std_event, 8'h00}, 16'h0000);
		chk(o_oper_enable, 16'h0010);
		chk({o_std_enable, o_srq_enable}, 16'hff80);
		// slow controller: a second rise while pending is ignored
		cyc(1);
		slow <= 1'b1;
		i_oper_cond <= 16'h0010;
		wait_srq(1'b1);
		chk(o_oper_cond, 16'h0010);
		chk({8'h00, o_stb_query}, 16'h00c0);
		oper_read();
		cyc(2);
		i_oper_cond <= 16'h0000;
		wait_srq(1'b0);
		chk({8'h00, seen}, 16'h00c0);
		repeat (8) @(negedge i_clk);
		chk({15'h0000, o_srq}, 16'h0000);
		cyc(1);
		slow <= 1'b0;
		oper_read();
		cyc(2);
		i_oper_cond <= 16'h0010;
		wait_srq(1'b1);
		wait_srq(1'b0);
		// random traffic judged by the checker
		for (int k = 0; k < 400; k++) begin
			cyc(1);
			r = $random(seed);
			i_ques_cond <= r[31:16];
			i_oper_cond <= {11'h000, r[0], 4'h0};
			{i_ques_evt_rd, i_oper_evt_rd, i_std_evt_rd} <= r[3:1];
			i_clear_status <= &r[7:4];
			i_std_event_set <= r[15:8] & {8{r[5]}};
			i_ques_en_wr <= r[9] & r[10];
			i_ques_en_data <= r[31:16] ^ r[15:0];
			{i_msg_avail, slow} <= r[12:11];
		end
		cyc(4);
		tally_and_finish();
	end
endmodule
